// ==== include/iexp_consts.vh ====
// constants for the interrupt expander with external interrupt channels
`ifndef IEXP_CONSTS_VH
`define IEXP_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define IEXP_OFF_ENA0     12'h000
`define IEXP_OFF_ENA1     12'h004
`define IEXP_OFF_ENA2     12'h008
`define IEXP_OFF_PEND0    12'h00C
`define IEXP_OFF_PEND1    12'h010
`define IEXP_OFF_PEND2    12'h014
`define IEXP_OFF_ACK      12'h018
`define IEXP_OFF_XCTL0    12'h020
`define IEXP_OFF_XCTL1    12'h024
`define IEXP_OFF_XCTL2    12'h028
`define IEXP_OFF_XCNT0    12'h030
`define IEXP_OFF_XCNT1    12'h034
`define IEXP_OFF_XCNT2    12'h038
`define IEXP_OFF_IRQST    12'h040
`define IEXP_OFF_IRQMSK   12'h044
`define IEXP_OFF_SERVE    12'h048
`define IEXP_OFF_VEC_BASE 12'h400
`define IEXP_OFF_VEC_TOP  12'h57C

// ----------------------------------------------------------------------
// external channel control fields
// ----------------------------------------------------------------------
`define IEXP_XCTL_EN_BIT  0
`define IEXP_XCTL_POL_LSB 1
`define IEXP_XCTL_POL_MSB 2
`define IEXP_XCTL_SEL_LSB 3
`define IEXP_XCTL_SEL_MSB 7
`define IEXP_POL_FALL     2'h0
`define IEXP_POL_RISE     2'h1
`define IEXP_POL_BOTH     2'h2

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define IEXP_RST_WORD     32'h00000000
`define IEXP_RST_CNT      16'h0000
`define IEXP_FETCH_CYC    4'h8
`define IEXP_SLVERR_OFF   1'b0

`endif

// ==== src/iexp_vec_ram.v ====
// vector memory: one word per request, registered read port
module iexp_vec_ram #(
  parameter DEPTH = 96,
  parameter AW    = 7,
  parameter DW    = 32
) (
  input  wire          pclk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);

  // ----------------------------------------------------------------------
  // storage; no reset, software loads it before enabling requests
  // ----------------------------------------------------------------------
  reg [DW-1:0] mem [0:DEPTH-1];

  // one write and one registered read per cycle
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// ==== src/iexp_top.v ====
// interrupt expander: grouped requests, vectors, external irq channels
//
// Behaviour
// - accept up to 96 peripheral requests
// - eight per group, twelve cpu lines
// - writable per-request vector ram
// - vector supplied; fetch takes eight cycles
// - per-request enable gates group line
// - fixed priority plus software enables
// - three external channels each with mask
// - falling, rising or both edge trigger
// - 16-bit counter cleared on valid edge
// - channel input chosen from pins 0..31
// - timer0 via expander, timers 1,2 direct
`include "iexp_consts.vh"

module iexp_top #(
  parameter NREQ = 96,
  parameter NGRP = 12,
  parameter NPIN = 32,
  parameter NX   = 3
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [11:0]      paddr,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output reg              pready,
  output reg              pslverr,
  input  wire [NREQ-1:0]  periph_irq,
  input  wire             timer_one_irq,
  input  wire             timer_two_irq,
  input  wire [NPIN-1:0]  general_pin,
  input  wire             cpu_ack,
  input  wire [3:0]       cpu_ack_line,
  output reg  [NGRP-1:0]  cpu_irq_line,
  output reg              cpu_irq_line_timer_one,
  output reg              cpu_irq_line_timer_two,
  output reg  [31:0]      cpu_vector,
  output reg              cpu_vector_valid,
  output reg              irq_out
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg  [NREQ-1:0] ena_r;          // per-request enables
  reg  [NREQ-1:0] pend_r;         // latched pending requests
  reg  [NPIN-1:0] pin_s1_r;       // pin synchroniser first stage
  reg  [NPIN-1:0] pin_s2_r;       // pin synchroniser second stage
  reg  [NX-1:0]   x_en_r;         // channel masks
  reg  [1:0]      x_pol_r [0:NX-1];
  reg  [4:0]      x_sel_r [0:NX-1];
  reg  [15:0]     x_cnt_r [0:NX-1];
  reg  [NX-1:0]   x_prev_r;       // last sampled selected pin level
  wire [NX-1:0]   x_fire;         // valid edge this cycle
  reg  [2:0]      ist_r;          // sticky events: ext ch0..2
  reg  [2:0]      imsk_r;         // interrupt mask
  reg             ack_s1_r;       // ack synchroniser
  reg             ack_s2_r;
  reg             ack_d_r;        // ack edge detect
  reg  [3:0]      ackl_s1_r;
  reg  [3:0]      ackl_s2_r;
  reg  [3:0]      fetch_cnt_r;    // vector fetch sequencer
  reg  [6:0]      fetch_idx_r;    // request being served
  reg  [6:0]      last_idx_r;     // last served request, readable
  reg  [1:0]      st_r;
  reg  [6:0]      win_idx;        // winner of selected group
  reg             win_ok;
  reg  [NREQ-1:0] src;            // request sources after routing
  wire            open_xfer;      // bus request not yet answered
  wire            ack_go;         // qualified acknowledge edge
  wire            wr;
  wire            vec_hit;
  wire [6:0]      vec_waddr;
  wire [6:0]      vec_raddr;
  wire [31:0]     vec_rdata;
  reg  [31:0]     rd_nxt;
  integer         i;

  localparam ST_IDLE  = 2'h0;     // waiting for an acknowledge
  localparam ST_FETCH = 2'h1;     // counting the fetch cycles
  localparam ST_BUSRD = 2'h2;     // apb vector read in flight

  // ----------------------------------------------------------------------
  // request routing
  // ----------------------------------------------------------------------
  // ext channels 0,1 sit at group 1 slots 4,5; ch2 at group 12 slot 1;
  // timer zero is one of the peripheral slots (group 1 slot 7)
  always @* begin
    src = periph_irq;
    src[3]  = periph_irq[3]  | x_fire[0];
    src[4]  = periph_irq[4]  | x_fire[1];
    src[88] = periph_irq[88] | x_fire[2];
  end

  // ----------------------------------------------------------------------
  // pin and acknowledge synchronisers
  // ----------------------------------------------------------------------
  // two flops before the channel selector reads any pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r  <= 32'h00000000;
      pin_s2_r  <= 32'h00000000;
      ack_s1_r  <= 1'b0;
      ack_s2_r  <= 1'b0;
      ackl_s1_r <= 4'h0;
      ackl_s2_r <= 4'h0;
      ack_d_r   <= 1'b0;
    end else begin
      pin_s1_r  <= general_pin;
      pin_s2_r  <= pin_s1_r;
      ack_s1_r  <= cpu_ack;
      ack_s2_r  <= ack_s1_r;
      ackl_s1_r <= cpu_ack_line;
      ackl_s2_r <= ackl_s1_r;
      ack_d_r   <= ack_s2_r;
    end
  end

  // ----------------------------------------------------------------------
  // external channels
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NX; g = g + 1) begin : g_x
      wire lvl  = pin_s2_r[x_sel_r[g]];
      wire rise = lvl & ~x_prev_r[g];
      wire fall = ~lvl & x_prev_r[g];
      // edge kind chosen by polarity field, gated by mask
      // polarity code three matches no edge: the channel is parked
      assign x_fire[g] = x_en_r[g] &
        ((x_pol_r[g] == `IEXP_POL_FALL) ? fall :
         (x_pol_r[g] == `IEXP_POL_RISE) ? rise :
         (x_pol_r[g] == `IEXP_POL_BOTH) ? (rise | fall) : 1'b0);

      // free-running stamp; clears on a valid edge, wraps naturally
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          x_cnt_r[g]  <= `IEXP_RST_CNT;
          x_prev_r[g] <= 1'b0;
        end else begin
          x_prev_r[g] <= lvl;
          if (x_fire[g]) begin
            x_cnt_r[g] <= `IEXP_RST_CNT;
          end else begin
            x_cnt_r[g] <= x_cnt_r[g] + 16'h0001;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  assign open_xfer = psel & ~pready;
  assign wr        = psel & penable & pready & pwrite;
  assign vec_hit   = (paddr >= `IEXP_OFF_VEC_BASE) &&
                     (paddr <= `IEXP_OFF_VEC_TOP);
  assign vec_waddr = paddr[8:2] - 7'h00;
  // memory port is shared: fetch sequencer owns it when serving
  assign vec_raddr = (st_r == ST_FETCH) ? fetch_idx_r : paddr[8:2];
  // an acknowledge counts once, at its synchronised rising edge, and
  // only for groups one to twelve holding a pending enabled request
  assign ack_go    = ack_s2_r & ~ack_d_r & win_ok &
                     (ackl_s2_r >= 4'h1) & (ackl_s2_r <= 4'hC);

  iexp_vec_ram #(
    .DEPTH (NREQ),
    .AW    (7),
    .DW    (32)
  ) u_vec (
    .pclk  (pclk),
    .we    (wr & vec_hit),
    .waddr (vec_waddr),
    .wdata (pwdata),
    .raddr (vec_raddr),
    .rdata (vec_rdata)
  );

  // ----------------------------------------------------------------------
  // group arbiter: lowest slot of acknowledged group wins
  // ----------------------------------------------------------------------
  // a group number outside one to twelve indexes past the request
  // vector; that never wins, and ack_go refuses it as well
  always @* begin
    win_idx = 7'h00;
    win_ok  = 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (pend_r[{ackl_s2_r, 3'h0} - 7'h08 + i[6:0]] &
          ena_r[{ackl_s2_r, 3'h0} - 7'h08 + i[6:0]]) begin
        win_idx = {ackl_s2_r, 3'h0} - 7'h08 + i[6:0];
        win_ok  = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // pending, enables, fetch sequencer, interrupt status
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ena_r       <= 96'h0;
      pend_r      <= 96'h0;
      st_r        <= ST_IDLE;
      fetch_cnt_r <= 4'h0;
      fetch_idx_r <= 7'h00;
      last_idx_r  <= 7'h00;
      ist_r       <= 3'h0;
      imsk_r      <= 3'h0;
      x_en_r      <= 3'h0;
      for (i = 0; i < NX; i = i + 1) begin
        x_pol_r[i] <= 2'h0;
        x_sel_r[i] <= 5'h00;
      end
    end else begin
      // event latch; a pending bit falls only when its vector is
      // delivered, and a still-asserted source re-pends it then
      pend_r <= pend_r | src;
      // status: set wins over write-one clear
      ist_r <= (ist_r & ~((wr && paddr == `IEXP_OFF_IRQST) ?
               pwdata[2:0] : 3'h0)) | x_fire;
      // software writes of configuration
      if (wr) begin
        case (paddr)
          `IEXP_OFF_ENA0:   ena_r[31:0]  <= pwdata;
          `IEXP_OFF_ENA1:   ena_r[63:32] <= pwdata;
          `IEXP_OFF_ENA2:   ena_r[95:64] <= pwdata;
          `IEXP_OFF_IRQMSK: imsk_r       <= pwdata[2:0];
          default: begin
            for (i = 0; i < NX; i = i + 1) begin
              if (paddr == `IEXP_OFF_XCTL0 + i * 4) begin
                x_en_r[i]  <= pwdata[`IEXP_XCTL_EN_BIT];
                x_pol_r[i] <= pwdata[`IEXP_XCTL_POL_MSB:
                                     `IEXP_XCTL_POL_LSB];
                x_sel_r[i] <= pwdata[`IEXP_XCTL_SEL_MSB:
                                     `IEXP_XCTL_SEL_LSB];
              end
            end
          end
        endcase
      end
      // acknowledge: pick winner, count eight cycles, deliver vector;
      // the vector ram port is shared, so a bus read may have to wait
      case (st_r)
        ST_IDLE: begin
          if (ack_go) begin
            st_r        <= ST_FETCH;
            fetch_idx_r <= win_idx;
            fetch_cnt_r <= 4'h1;
          end else if (open_xfer & vec_hit & ~pwrite) begin
            // any unanswered vector read, not only its setup cycle, so
            // a read that waited behind a fetch still gets its turn
            st_r <= ST_BUSRD;
          end
        end
        ST_FETCH: begin
          if (fetch_cnt_r == `IEXP_FETCH_CYC) begin
            st_r       <= ST_IDLE;
            last_idx_r <= fetch_idx_r;
            pend_r[fetch_idx_r] <= src[fetch_idx_r];
          end
          fetch_cnt_r <= fetch_cnt_r + 4'h1;
        end
        ST_BUSRD: begin
          // an acknowledge edge lasts one cycle; losing it here would
          // leave the core waiting for a vector that never comes
          if (ack_go) begin
            st_r        <= ST_FETCH;
            fetch_idx_r <= win_idx;
            fetch_cnt_r <= 4'h1;
          end else begin
            st_r <= ST_IDLE;
          end
        end
        default:  st_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always @* begin
    rd_nxt = `IEXP_RST_WORD;
    case (paddr)
      `IEXP_OFF_ENA0:   rd_nxt = ena_r[31:0];
      `IEXP_OFF_ENA1:   rd_nxt = ena_r[63:32];
      `IEXP_OFF_ENA2:   rd_nxt = ena_r[95:64];
      `IEXP_OFF_PEND0:  rd_nxt = pend_r[31:0];
      `IEXP_OFF_PEND1:  rd_nxt = pend_r[63:32];
      `IEXP_OFF_PEND2:  rd_nxt = pend_r[95:64];
      `IEXP_OFF_XCTL0:  rd_nxt = {24'h0, x_sel_r[0], x_pol_r[0], x_en_r[0]};
      `IEXP_OFF_XCTL1:  rd_nxt = {24'h0, x_sel_r[1], x_pol_r[1], x_en_r[1]};
      `IEXP_OFF_XCTL2:  rd_nxt = {24'h0, x_sel_r[2], x_pol_r[2], x_en_r[2]};
      `IEXP_OFF_XCNT0:  rd_nxt = {16'h0, x_cnt_r[0]};
      `IEXP_OFF_XCNT1:  rd_nxt = {16'h0, x_cnt_r[1]};
      `IEXP_OFF_XCNT2:  rd_nxt = {16'h0, x_cnt_r[2]};
      `IEXP_OFF_IRQST:  rd_nxt = {29'h0, ist_r};
      `IEXP_OFF_IRQMSK: rd_nxt = {29'h0, imsk_r};
      `IEXP_OFF_SERVE:  rd_nxt = {25'h0, last_idx_r};
      default:          rd_nxt = vec_hit ? vec_rdata : `IEXP_RST_WORD;
    endcase
  end

  // ----------------------------------------------------------------------
  // apb answer and cpu-side outputs
  // ----------------------------------------------------------------------
  // a vector read is answered from the ram output loaded during its
  // setup cycle; while a fetch holds the ram port the read waits
  // prdata reloads every cycle, only the pready cycle carries meaning
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata                 <= `IEXP_RST_WORD;
      pready                 <= 1'b0;
      pslverr                <= `IEXP_SLVERR_OFF;
      cpu_irq_line           <= 12'h000;
      cpu_irq_line_timer_one <= 1'b0;
      cpu_irq_line_timer_two <= 1'b0;
      cpu_vector             <= `IEXP_RST_WORD;
      cpu_vector_valid       <= 1'b0;
      irq_out                <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready &
                 (~vec_hit | pwrite | st_r == ST_BUSRD);
      prdata  <= rd_nxt;
      pslverr <= `IEXP_SLVERR_OFF;
      for (i = 0; i < NGRP; i = i + 1) begin
        cpu_irq_line[i] <= |(pend_r[i*8 +: 8] & ena_r[i*8 +: 8]);
      end
      cpu_irq_line_timer_one <= timer_one_irq;
      cpu_irq_line_timer_two <= timer_two_irq;
      cpu_vector_valid <= (st_r == ST_FETCH) &&
                          (fetch_cnt_r == `IEXP_FETCH_CYC);
      if (st_r == ST_FETCH && fetch_cnt_r == `IEXP_FETCH_CYC) begin
        cpu_vector <= vec_rdata;
      end
      irq_out <= |(ist_r & imsk_r);
    end
  end

endmodule

// ==== tb/iexp_core_model.sv ====
// processor core model: services grouped lines and collects vectors
module iexp_core_model (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         run,
  input  wire  [7:0]  lag,
  input  wire  [11:0] cpu_irq_line,
  input  wire  [31:0] cpu_vector,
  input  wire         cpu_vector_valid,
  output logic        cpu_ack,
  output logic [3:0]  cpu_ack_line,
  output logic [31:0] core_vec,
  output logic [7:0]  served
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_r; // idle cycles before taking the next line
  // lowest active line, numbered from one
  function automatic logic [3:0] first_line(input logic [11:0] l);
    first_line = 4'h0;
    for (int i = 11; i >= 0; i--)
      if (l[i])
        first_line = 4'(i + 1);
  endfunction
  // ack and group stay put until the vector arrives
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 1'b0;
      cpu_ack_line <= 4'h0;
      core_vec <= 32'h00000000;
      served <= 8'h00;
      wait_r <= 8'h00;
    end else if (cpu_ack) begin
      if (cpu_vector_valid) begin
        cpu_ack <= 1'b0;
        cpu_ack_line <= ~cpu_ack_line; // released: group number inverted, not held
        core_vec <= cpu_vector;
        served <= served + 8'h01;
        wait_r <= 8'h00;
      end
    end else if (run && cpu_irq_line != 12'h000) begin
      // lag lets the design's synchroniser see the ack low first
      if (wait_r >= lag) begin
        cpu_ack <= 1'b1;
        cpu_ack_line <= first_line(cpu_irq_line);
      end else
        wait_r <= wait_r + 8'h01;
    end
  end
endmodule

// ==== tb/iexp_top_asserts.sv ====
// port checker for the interrupt expander, bound to its top
`include "iexp_consts.vh"
module iexp_chk #(
  parameter NREQ = 96,
  parameter NGRP = 12
) (
  input wire            pclk,
  input wire            presetn,
  input wire [11:0]     paddr,
  input wire            psel,
  input wire            penable,
  input wire            pwrite,
  input wire [31:0]     pwdata,
  input wire            pready,
  input wire            timer_one_irq,
  input wire            timer_two_irq,
  input wire            cpu_ack,
  input wire [NGRP-1:0] cpu_irq_line,
  input wire            cpu_irq_line_timer_one,
  input wire            cpu_irq_line_timer_two,
  input wire            cpu_vector_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----
  // enables as software last wrote them
  // ----
  reg  [NREQ-1:0] ena_r;
  wire [NGRP-1:0] grp_en; // group holds an enabled slot
  genvar g;
  for (g = 0; g < NGRP; g = g + 1) begin : g_grp
    assign grp_en[g] = |ena_r[g*8 +: 8];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ena_r <= '0;
    else if (psel && penable && pready && pwrite && paddr < `IEXP_OFF_PEND0)
      ena_r[paddr[3:2]*32 +: 32] <= pwdata;
  end
  property p_tmr1;
    cpu_irq_line_timer_one == $past(timer_one_irq);
  endproperty
  a_tmr1: assert property (p_tmr1) else $error("timer one line");
  property p_tmr2;
    cpu_irq_line_timer_two == $past(timer_two_irq);
  endproperty
  a_tmr2: assert property (p_tmr2) else $error("timer two line");
  property p_grp;
    (cpu_irq_line & ~grp_en & ~$past(grp_en)) == '0;
  endproperty
  a_grp: assert property (p_grp) else $error("disabled group");
  property p_vpls;
    cpu_vector_valid |=> !cpu_vector_valid;
  endproperty
  a_vpls: assert property (p_vpls) else $error("valid too long");
  property p_fmin;
    $rose(cpu_ack) |=> !cpu_vector_valid [*8];
  endproperty
  a_fmin: assert property (p_fmin) else $error("fetch too short");
  property p_fack;
    cpu_vector_valid |-> $past(cpu_ack, 8);
  endproperty
  a_fack: assert property (p_fack) else $error("vector unasked");
  property p_vrd;
    $rose(penable) && psel && !pwrite && paddr >= `IEXP_OFF_VEC_BASE
      |-> !pready ##[1:20] pready;
  endproperty
  a_vrd: assert property (p_vrd) else $error("vector read timing");
  property p_rrdy;
    $rose(penable) && psel && paddr < `IEXP_OFF_VEC_BASE |=> pready;
  endproperty
  a_rrdy: assert property (p_rrdy) else $error("register ready late");
  c_vld: cover property (cpu_vector_valid);
  c_g12: cover property (cpu_irq_line[NGRP-1]);
  c_tmr: cover property (cpu_irq_line_timer_one);
endmodule
bind iexp_top iexp_chk #(.NREQ(NREQ), .NGRP(NGRP)) u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .timer_one_irq(timer_one_irq), .timer_two_irq(timer_two_irq),
  .cpu_ack(cpu_ack), .cpu_irq_line(cpu_irq_line),
  .cpu_irq_line_timer_one(cpu_irq_line_timer_one),
  .cpu_irq_line_timer_two(cpu_irq_line_timer_two),
  .cpu_vector_valid(cpu_vector_valid)
);

// ==== tb/tb.sv ====
// self-checking bench for the interrupt expander
`include "iexp_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [95:0] pirq = '0;          // peripheral requests
  logic        t1 = 1'b0;
  logic        t2 = 1'b0;
  logic [31:0] pin = 32'h00000000; // general pins
  logic        run = 1'b0;         // core model may take lines
  logic [7:0]  lag = 8'h03;        // core model reaction time
  wire  [31:0] prdata, cvec, core_vec;
  wire  [11:0] line;
  wire  [7:0]  served;
  wire  [3:0]  ack_line;
  wire         pready, ack, tl1, tl2, vld, irq, slverr;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cyc = 0;
  iexp_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(slverr), .periph_irq(pirq),
    .timer_one_irq(t1), .timer_two_irq(t2), .general_pin(pin),
    .cpu_ack(ack), .cpu_ack_line(ack_line), .cpu_irq_line(line),
    .cpu_irq_line_timer_one(tl1), .cpu_irq_line_timer_two(tl2),
    .cpu_vector(cvec), .cpu_vector_valid(vld), .irq_out(irq));
  iexp_core_model core (.pclk(pclk), .presetn(presetn), .run(run),
    .lag(lag), .cpu_irq_line(line), .cpu_vector(cvec),
    .cpu_vector_valid(vld), .cpu_ack(ack), .cpu_ack_line(ack_line),
    .core_vec(core_vec), .served(served));
  always #4 pclk = ~pclk;
  // hang guard: the wrap test alone needs some 70000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      miscompares++;
      summarize();
    end
  end
  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h00000000, q);
    chk(q, e);
    chk({31'h0, slverr}, 32'h0); // error response never given
  endtask
  // pulse requests for one cycle, then let the group line settle
  task automatic fire(input logic [95:0] m, input logic [31:0] e);
    pirq <= m;
    @(posedge pclk);
    pirq <= '0;
    repeat (4) @(posedge pclk);
    chk({20'h0, line}, e);
  endtask
  task automatic got(input logic [7:0] n, input logic [31:0] e);
    while (served !== n) @(posedge pclk);
    chk(core_vec, e);
  endtask
  // pin step on channel 0; a fresh stamp is a small count
  task automatic xstep(input int p, input logic lv, input logic clr);
    logic [31:0] q;
    pin[p] <= lv;
    repeat (6) @(posedge pclk);
    apb(1'b0, `IEXP_OFF_XCNT0, 32'h00000000, q);
    chk({31'h0, q < 32'h10}, {31'h0, clr});
    repeat (24) @(posedge pclk);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reg;
    rd(`IEXP_OFF_ENA0, `IEXP_RST_WORD);
    rd(`IEXP_OFF_IRQMSK, `IEXP_RST_WORD);
    wr(12'h100, 32'hFFFFFFFF);
    rd(12'h100, 32'h00000000);
    wr(`IEXP_OFF_PEND0, 32'hFFFFFFFF);
    rd(`IEXP_OFF_PEND0, 32'h00000000);
  endtask
  task automatic t_tmr;
    t1 <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({30'h0, tl2, tl1}, 32'h1);
    t1 <= 1'b0;
    t2 <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({30'h0, tl2, tl1}, 32'h2);
    t2 <= 1'b0;
  endtask
  task automatic t_vec;
    wr(`IEXP_OFF_VEC_BASE, 32'h0000A000);
    wr(`IEXP_OFF_VEC_BASE + 12'h004, 32'h0000A004);
    wr(`IEXP_OFF_VEC_BASE + 12'h018, 32'h0000A018);
    wr(`IEXP_OFF_VEC_TOP, 32'h0000B17C);
    rd(`IEXP_OFF_VEC_TOP, 32'h0000B17C);
    wr(`IEXP_OFF_ENA0, 32'h00000043);
    fire(96'h47, 32'h1);
    run <= 1'b1;
    got(8'h01, 32'h0000A000);
    got(8'h02, 32'h0000A004);
    got(8'h03, 32'h0000A018);
    repeat (4) @(posedge pclk);
    chk({20'h0, line}, 32'h0);
    lag <= 8'h28;
    wr(`IEXP_OFF_ENA2, 32'h80000000);
    fire({1'b1, 95'h0}, 32'h800);
    got(8'h04, 32'h0000B17C);
    wr(`IEXP_OFF_VEC_BASE, 32'h0000C000);
    fire(96'h1, 32'h1);
    got(8'h05, 32'h0000C000);
  endtask
  task automatic t_ext;
    logic [31:0] q, q2, d;
    wr(`IEXP_OFF_XCTL0, 32'h000000FB);
    xstep(31, 1'b1, 1'b1);
    xstep(31, 1'b0, 1'b0);
    xstep(0, 1'b1, 1'b0);
    wr(`IEXP_OFF_XCTL0, 32'h000000F9);
    xstep(31, 1'b1, 1'b0);
    xstep(31, 1'b0, 1'b1);
    wr(`IEXP_OFF_XCTL0, 32'h000000FD);
    xstep(31, 1'b1, 1'b1);
    xstep(31, 1'b0, 1'b1);
    wr(`IEXP_OFF_XCTL0, 32'h000000FC);
    xstep(31, 1'b1, 1'b0);
    // status sticks, mask decides the output, a one clears it
    apb(1'b0, `IEXP_OFF_IRQST, 32'h00000000, q);
    chk({31'h0, q != 32'h0}, 32'h1);
    wr(`IEXP_OFF_IRQMSK, 32'h00000000);
    repeat (2) @(posedge pclk); // irq_out follows the mask a cycle late
    d[0] = irq;
    wr(`IEXP_OFF_IRQMSK, 32'hFFFFFFFF);
    repeat (2) @(posedge pclk);
    chk({31'h0, d[0] ^ irq}, 32'h1);
    wr(`IEXP_OFF_IRQST, q);
    rd(`IEXP_OFF_IRQST, 32'h00000000);
    chk({31'h0, irq}, 32'h0);
    // free run across a wrap: stamp delta equals elapsed cycles
    apb(1'b0, `IEXP_OFF_XCNT0, 32'h00000000, q);
    d = cyc;
    repeat (70000) @(posedge pclk);
    apb(1'b0, `IEXP_OFF_XCNT0, 32'h00000000, q2);
    d = cyc - d;
    chk({16'h0, q2[15:0] - q[15:0]}, {16'h0, d[15:0]});
  endtask
  task automatic summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reg();
    t_tmr();
    t_vec();
    t_ext();
    summarize();
  end
endmodule
